// [verilog/diaml_pkg.sv]
package diaml_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_INIT_GAIN = 8'h04;
    localparam logic [7:0] OFF_PID_LEVEL = 8'h08;
    localparam logic [7:0] OFF_GAIN_TAU = 8'h0c;
    localparam logic [7:0] OFF_STEADY_TAU = 8'h10;
    localparam logic [7:0] OFF_STEADY_LEV = 8'h14;
    localparam logic [7:0] OFF_GAIN_MON = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1c;
    localparam logic [7:0] OFF_SPEED_CMD = 8'h20;

    // Control field positions
    localparam int CTRL_DIA_EN_BIT = 0;
    localparam int CTRL_RAMP_EN_BIT = 1;
    localparam int CTRL_MODE_LSB = 2;

    // Status field positions
    localparam int STAT_RUN_BIT = 0;
    localparam int STAT_STEADY_BIT = 1;
    localparam int STAT_ACTIVE_BIT = 2;

    // Tension control mode codes
    localparam logic [1:0] MODE_OTHER = 2'h0;
    localparam logic [1:0] MODE_WINDER_CLOSED_SPEED = 2'h1;
    localparam logic [1:0] MODE_UNWINDER_CLOSED_SPEED = 2'h2;

    // Reset values: gain 0.1 %, levels 0.01 %, times 0.1 s
    localparam logic [15:0] INIT_GAIN_RST = 16'h03e8;
    localparam logic [15:0] PID_LEVEL_RST = 16'h03e8;
    localparam logic [15:0] GAIN_TAU_RST = 16'h01f4;
    localparam logic [15:0] STEADY_TAU_RST = 16'h000a;
    localparam logic [15:0] STEADY_LEV_RST = 16'h0064;
    localparam logic [1:0] MODE_RST = 2'h0;

    // Setting ranges
    localparam logic [15:0] GAIN_MAX = 16'h0bb8;
    localparam logic [15:0] PID_LEVEL_MAX = 16'h2710;
    localparam logic [15:0] GAIN_TAU_MAX = 16'h0bb8;
    localparam logic [15:0] STEADY_TAU_MAX = 16'h03e8;
    localparam logic [15:0] STEADY_LEV_MAX = 16'h1388;

    // Gain 100.0 % in 0.1 % units
    localparam int GAIN_UNITY = 1000;
    // Gain change per rate period, 0.1 %
    localparam logic [15:0] GAIN_STEP = 16'h0001;
    // Control ticks per 0.1 s at the default 1 kHz tick
    localparam int TICKS_PER_TENTH_DEF = 100;
    // Filter step shift
    localparam int LPF_SHIFT = 4;

endpackage

// [verilog/steady_lpf.sv]
`timescale 1ns/1ns
module steady_lpf
    import diaml_pkg::*;
#(
    parameter int TICKS_PER_TENTH = TICKS_PER_TENTH_DEF
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic tick,
    input wire logic [15:0] x,
    input wire logic [15:0] tau,
    output logic [15:0] y
);

    typedef struct packed {
        logic [15:0] y;
        logic [27:0] cnt;
    } lpf_state_t;

    lpf_state_t st_reg;
    lpf_state_t st_next;
    logic [27:0] period;
    logic signed [16:0] diff;
    logic signed [16:0] step;

    always_comb
    begin
        st_next = st_reg;
        period = 28'((tau * TICKS_PER_TENTH) >> LPF_SHIFT);
        diff = $signed({1'b0, x}) - $signed({1'b0, st_reg.y});
        step = diff >>> LPF_SHIFT;
        // Keep converging once the shifted step vanishes
        if (step == 17'sh0_0000 && diff != 17'sh0_0000)
        begin
            step = (diff < 0) ? -17'sh0_0001 : 17'sh0_0001;
        end
        if (tau == 16'h0000)
        begin
            st_next.y = x;
            st_next.cnt = '0;
        end
        else if (tick)
        begin
            if (st_reg.cnt + 28'h000_0001 >= period)
            begin
                st_next.cnt = '0;
                st_next.y = 16'(st_reg.y + 16'(step));
            end
            else
            begin
                st_next.cnt = st_reg.cnt + 28'h000_0001;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_reg <= '0;
        end
        else if (ce)
        begin
            st_reg <= st_next;
        end
    end

    assign y = st_reg.y;

endmodule // steady_lpf

// [verilog/diameterless_comp_gain.sv]
// Function
// - Diameterless: speed command from main speed times gain plus PID output.
// - Gain function acts only in winder or unwinder closed-loop speed mode.
// - Initial gain settable 0.0 to 300.0 %, default 100.0 %, loaded first.
// - On stop the working gain reloads from the initial gain setting.
// - While running gain follows PID versus reference; monitor is read-only.
// - Gain rises while PID exceeds reference; reference 0.00 to 100.00, default 10.00.
// - Gain falls below negative reference, holds between the two thresholds.
// - Filter time 0.0 to 300.0 s, default 50.0 s; smaller is faster.
// - Ramp computation off: gain updates only in constant-speed zones.
// - Ramp computation on: gain updates during accel, decel and constant speed.
// - Output frequency low-pass filtered, time 0.0 to 100.0 s, default 1.0 s.
// - Frequency minus filtered copy above threshold freezes gain; 0.00 to 50.00 %.
`timescale 1ns/1ns
module diameterless_comp_gain
    import diaml_pkg::*;
#(
    parameter int TICKS_PER_TENTH = TICKS_PER_TENTH_DEF
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tick,
    input wire logic run,
    input wire logic signed [15:0] main_speed,
    input wire logic signed [15:0] pid_out,
    input wire logic [15:0] out_freq,
    output logic signed [15:0] speed_cmd,
    output logic [15:0] gain_monitor,
    output logic steady_zone
);

    // Direction of the gain integrator
    typedef enum logic [1:0] {
        DIR_HOLD = 2'h0,
        DIR_UP = 2'h1,
        DIR_DOWN = 2'h2
    } dir_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic dia_en;
        logic ramp_en;
        logic [1:0] tmode;
        logic [15:0] init_gain;
        logic [15:0] pid_level;
        logic [15:0] gain_tau;
        logic [15:0] steady_tau;
        logic [15:0] steady_lev;
        logic [15:0] gain;
        logic [27:0] rate_cnt;
        dir_t dir;
        logic signed [15:0] speed_cmd;
        logic steady;
        logic run_seen;
        logic active;
    } state_t;

    localparam state_t ST_RESET = '{
        tmode: MODE_RST,
        init_gain: INIT_GAIN_RST,
        pid_level: PID_LEVEL_RST,
        gain_tau: GAIN_TAU_RST,
        steady_tau: STEADY_TAU_RST,
        steady_lev: STEADY_LEV_RST,
        gain: INIT_GAIN_RST,
        dir: DIR_HOLD,
        default: '0
    };

    localparam logic signed [33:0] CMD_MAX = 34'sh0_0000_7fff;
    localparam logic signed [33:0] CMD_MIN = -34'sh0_0000_8000;

    state_t st_reg;
    state_t st_next;
    logic [15:0] freq_filt;
    logic active;
    logic go_up;
    logic go_down;
    logic update_ok;
    dir_t dir_now;
    logic [27:0] rate_limit;
    logic [16:0] freq_diff;
    logic signed [33:0] scaled;
    logic signed [33:0] cmd_sum;
    logic wr_acc;

    function automatic logic [15:0] clamp16(input logic [31:0] v, input logic [15:0] vmax);
        clamp16 = (v > {16'h0000, vmax}) ? vmax : v[15:0];
    endfunction

    steady_lpf #(
        .TICKS_PER_TENTH(TICKS_PER_TENTH)
    ) u_lpf (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .tick(tick),
        .x(out_freq),
        .tau(st_reg.steady_tau),
        .y(freq_filt)
    );

    always_comb
    begin
        st_next = st_reg;
        wr_acc = psel && penable && st_reg.pready && pwrite;

        // Zero-wait APB slave with registered read data
        st_next.pready = 1'b0;
        st_next.pslverr = 1'b0;
        if (psel && !penable && !st_reg.pready)
        begin
            st_next.pready = 1'b1;
            st_next.prdata = 32'h0000_0000;
            case (paddr)
                OFF_CTRL:
                begin
                    st_next.prdata[CTRL_DIA_EN_BIT] = st_reg.dia_en;
                    st_next.prdata[CTRL_RAMP_EN_BIT] = st_reg.ramp_en;
                    st_next.prdata[CTRL_MODE_LSB +: 2] = st_reg.tmode;
                end
                OFF_INIT_GAIN: st_next.prdata[15:0] = st_reg.init_gain;
                OFF_PID_LEVEL: st_next.prdata[15:0] = st_reg.pid_level;
                OFF_GAIN_TAU: st_next.prdata[15:0] = st_reg.gain_tau;
                OFF_STEADY_TAU: st_next.prdata[15:0] = st_reg.steady_tau;
                OFF_STEADY_LEV: st_next.prdata[15:0] = st_reg.steady_lev;
                OFF_GAIN_MON: st_next.prdata[15:0] = st_reg.gain;
                OFF_STATUS:
                begin
                    st_next.prdata[STAT_RUN_BIT] = st_reg.run_seen;
                    st_next.prdata[STAT_STEADY_BIT] = st_reg.steady;
                    st_next.prdata[STAT_ACTIVE_BIT] = st_reg.active;
                end
                OFF_SPEED_CMD: st_next.prdata[15:0] = st_reg.speed_cmd;
                default: st_next.pslverr = 1'b1;
            endcase
            // Writes to read-only words are refused
            if (pwrite && (paddr == OFF_GAIN_MON || paddr == OFF_STATUS
                || paddr == OFF_SPEED_CMD))
            begin
                st_next.pslverr = 1'b1;
            end
        end

        if (wr_acc && !st_reg.pslverr)
        begin
            case (paddr)
                OFF_CTRL:
                begin
                    st_next.dia_en = pwdata[CTRL_DIA_EN_BIT];
                    st_next.ramp_en = pwdata[CTRL_RAMP_EN_BIT];
                    st_next.tmode = pwdata[CTRL_MODE_LSB +: 2];
                end
                OFF_INIT_GAIN: st_next.init_gain = clamp16(pwdata, GAIN_MAX);
                OFF_PID_LEVEL: st_next.pid_level = clamp16(pwdata, PID_LEVEL_MAX);
                OFF_GAIN_TAU: st_next.gain_tau = clamp16(pwdata, GAIN_TAU_MAX);
                OFF_STEADY_TAU: st_next.steady_tau = clamp16(pwdata, STEADY_TAU_MAX);
                OFF_STEADY_LEV: st_next.steady_lev = clamp16(pwdata, STEADY_LEV_MAX);
                default:
                begin
                end
            endcase
        end

        // Function enabled only in closed-loop speed modes
        active = st_reg.dia_en && (st_reg.tmode == MODE_WINDER_CLOSED_SPEED
            || st_reg.tmode == MODE_UNWINDER_CLOSED_SPEED);
        st_next.active = active;
        st_next.run_seen = run;

        // Constant-speed judgment
        freq_diff = (out_freq >= freq_filt) ? 17'(out_freq - freq_filt)
            : 17'(freq_filt - out_freq);
        st_next.steady = (freq_diff <= {1'b0, st_reg.steady_lev});
        update_ok = st_reg.ramp_en || st_reg.steady;

        go_up = $signed({pid_out[15], pid_out}) > $signed({1'b0, st_reg.pid_level});
        go_down = $signed({pid_out[15], pid_out}) < -$signed({1'b0, st_reg.pid_level});
        if (go_up)
        begin
            dir_now = DIR_UP;
        end
        else if (go_down)
        begin
            dir_now = DIR_DOWN;
        end
        else
        begin
            dir_now = DIR_HOLD;
        end
        rate_limit = 28'(st_reg.gain_tau * TICKS_PER_TENTH);

        if (!run || !active)
        begin
            st_next.gain = st_next.init_gain;
            st_next.rate_cnt = '0;
            st_next.dir = DIR_HOLD;
        end
        else if (tick && update_ok)
        begin
            st_next.dir = dir_now;
            if (dir_now == DIR_HOLD || dir_now != st_reg.dir)
            begin
                st_next.rate_cnt = '0;
            end
            else if (st_reg.rate_cnt + 28'h000_0001 >= rate_limit)
            begin
                st_next.rate_cnt = '0;
                // Saturating integrator step
                if (dir_now == DIR_UP)
                begin
                    st_next.gain = (st_reg.gain >= GAIN_MAX - GAIN_STEP) ? GAIN_MAX
                        : st_reg.gain + GAIN_STEP;
                end
                else
                begin
                    st_next.gain = (st_reg.gain <= GAIN_STEP) ? 16'h0000
                        : st_reg.gain - GAIN_STEP;
                end
            end
            else
            begin
                st_next.rate_cnt = st_reg.rate_cnt + 28'h000_0001;
            end
            // First tick of a new direction steps at once when the rate limit is at most one tick
            if (dir_now != DIR_HOLD && dir_now != st_reg.dir && rate_limit <= 28'h000_0001)
            begin
                if (dir_now == DIR_UP)
                begin
                    st_next.gain = (st_reg.gain >= GAIN_MAX - GAIN_STEP) ? GAIN_MAX
                        : st_reg.gain + GAIN_STEP;
                end
                else
                begin
                    st_next.gain = (st_reg.gain <= GAIN_STEP) ? 16'h0000
                        : st_reg.gain - GAIN_STEP;
                end
            end
        end

        // Speed command: main * gain / 100 % + PID, or main + PID when inactive, saturated
        scaled = $signed({{18{main_speed[15]}}, main_speed}) * $signed({18'h0_0000, st_reg.gain});
        scaled = scaled / 34'(GAIN_UNITY);
        if (!active)
        begin
            scaled = $signed({{18{main_speed[15]}}, main_speed});
        end
        cmd_sum = scaled + $signed({{18{pid_out[15]}}, pid_out});
        if (cmd_sum > CMD_MAX)
        begin
            st_next.speed_cmd = 16'sh7fff;
        end
        else if (cmd_sum < CMD_MIN)
        begin
            st_next.speed_cmd = -16'sh8000;
        end
        else
        begin
            st_next.speed_cmd = cmd_sum[15:0];
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_reg <= ST_RESET;
        end
        else if (ce)
        begin
            st_reg <= st_next;
        end
    end

    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign speed_cmd = st_reg.speed_cmd;
    assign gain_monitor = st_reg.gain;
    assign steady_zone = st_reg.steady;

endmodule // diameterless_comp_gain

// [test/diaml_checker_assertions.sv]
`timescale 1ns/1ns
module diaml_checker
    import diaml_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic tick,
    input wire logic run,
    input wire logic signed [15:0] main_speed,
    input wire logic signed [15:0] pid_out,
    input wire logic [15:0] out_freq,
    input wire logic signed [15:0] speed_cmd,
    input wire logic [15:0] gain_monitor,
    input wire logic steady_zone
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    sequence s_setup;
        ce && psel && !penable;
    endsequence
    // Unity gain out of reset, no saturation possible
    sequence s_unity;
        ce && gain_monitor == GAIN_UNITY && main_speed < 16'sh1f40 && main_speed > -16'sh1f40
            && pid_out < 16'sh1f40 && pid_out > -16'sh1f40 && rstn;
    endsequence
    property p_answer;
        s_setup |=> pready ##1 !pready;
    endproperty
    property p_idle;
        !psel |=> !pready;
    endproperty
    property p_err;
        pslverr |-> pready;
    endproperty
    property p_ro;
        s_setup and pwrite && paddr == OFF_GAIN_MON |=> pslverr;
    endproperty
    property p_mon_read;
        s_setup and !pwrite && paddr == OFF_GAIN_MON |=> prdata == {16'h0000, $past(gain_monitor)};
    endproperty
    property p_range;
        gain_monitor <= GAIN_MAX;
    endproperty
    property p_step;
        ce && run && $past(run) && $changed(gain_monitor) |->
            gain_monitor == $past(gain_monitor) + 16'h0001
            || gain_monitor == $past(gain_monitor) - 16'h0001;
    endproperty
    property p_cmd;
        s_unity ##1 gain_monitor == GAIN_UNITY |-> speed_cmd == $past(main_speed) + $past(pid_out);
    endproperty
    a_answer: assert property (p_answer) else $error("ready not one cycle after setup");
    a_idle: assert property (p_idle) else $error("ready without setup");
    a_err: assert property (p_err) else $error("error without ready");
    a_ro: assert property (p_ro) else $error("monitor write accepted");
    a_mon_read: assert property (p_mon_read) else $error("monitor read wrong");
    a_range: assert property (p_range) else $error("gain above range");
    a_step: assert property (p_step) else $error("gain step not one unit");
    a_cmd: assert property (p_cmd) else $error("speed command wrong");
endmodule // diaml_checker

bind diameterless_comp_gain diaml_checker diaml_checker_i (.clk, .rstn, .ce, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .tick, .run, .main_speed, .pid_out,
    .out_freq, .speed_cmd, .gain_monitor, .steady_zone);

// [test/tb_diameterless_comp_gain.sv]
`timescale 1ns/1ns
`define CHK(a, e) \
    begin \
        checks_done++; \
        if ((a) !== (e)) \
        begin \
            mismatches++; \
            $display("MISMATCH t=%0t got %h exp %h", $time, a, e); \
        end \
    end
module tb_diameterless_comp_gain
    import diaml_pkg::*;
;
    localparam logic [7:0] RA [6] = '{OFF_CTRL, OFF_INIT_GAIN, OFF_PID_LEVEL, OFF_GAIN_TAU,
        OFF_STEADY_TAU, OFF_STEADY_LEV};
    localparam logic [15:0] RV [6] = '{16'h0000, INIT_GAIN_RST, PID_LEVEL_RST, GAIN_TAU_RST,
        STEADY_TAU_RST, STEADY_LEV_RST};
    localparam logic [31:0] CV [5] = '{32'h0000_0003, 32'h0000_0007, 32'h0000_000b,
        32'h0000_000f, 32'h0000_0006};
    localparam logic signed [15:0] PV [4] = '{16'sh03e8, -16'sh03e8, 16'sh07d0, -16'sh07d0};
    localparam logic [1:0] PE [4] = '{2'h0, 2'h0, 2'h2, 2'h1};
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic tick = 1'b0;
    logic run = 1'b0;
    logic signed [15:0] main_speed = 16'sh0000;
    logic signed [15:0] pid_out = 16'sh0000;
    logic [15:0] out_freq = 16'h0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic signed [15:0] speed_cmd;
    logic [15:0] gain_monitor;
    logic steady_zone;
    logic [1:0] tcnt = 2'h0;
    logic [31:0] rd;
    logic er;
    logic [15:0] g0;
    int mismatches = 0;
    int checks_done = 0;

    always #10 clk = ~clk;

    // Control tick every fourth clock
    always @(posedge clk)
    begin
        tcnt <= tcnt + 2'h1;
        tick <= (tcnt == 2'h3);
    end

    diameterless_comp_gain #(.TICKS_PER_TENTH(2)) diameterless_comp_gain_i (.clk, .rstn,
        .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .tick, .run, .main_speed, .pid_out, .out_freq, .speed_cmd, .gain_monitor, .steady_zone);

    task report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
        begin
            $display("All checks passed");
        end
        else
        begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            mismatches++;
            report_and_stop();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic spin(input logic signed [15:0] p, input int k);
        @(posedge clk);
        pid_out <= p;
        run <= 1'b1;
        repeat (k) @(posedge clk);
    endtask

    task automatic halt;
        @(posedge clk);
        run <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    initial
    begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b0, RA[i], 32'h0000_0000);
            `CHK(rd, {16'h0000, RV[i]})
        end
        apb(1'b0, 8'h24, 32'h0000_0000);
        `CHK({er, rd}, {1'b1, 32'h0000_0000})
        apb(1'b1, OFF_GAIN_MON, 32'h0000_0007);
        `CHK(er, 1'b1)
        $display("test registers done");
        main_speed <= 16'sh07d0;
        pid_out <= 16'sh012c;
        repeat (3) @(posedge clk);
        `CHK(speed_cmd, 16'sh08fc)
        apb(1'b1, OFF_GAIN_TAU, 32'h0000_0001);
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b1, OFF_CTRL, CV[i]);
            spin(16'sh07d0, 40);
            `CHK(gain_monitor != INIT_GAIN_RST, (i == 1 || i == 2))
            halt();
        end
        apb(1'b1, OFF_CTRL, 32'h0000_0007);
        for (int i = 0; i < 4; i++)
        begin
            spin(PV[i], 40);
            `CHK({gain_monitor > INIT_GAIN_RST, gain_monitor < INIT_GAIN_RST}, PE[i])
            halt();
        end
        // Longer filter time gives a slower gain change
        apb(1'b1, OFF_GAIN_TAU, 32'h0000_0004);
        spin(16'sh07d0, 80);
        g0 = gain_monitor;
        halt();
        apb(1'b1, OFF_GAIN_TAU, 32'h0000_0001);
        spin(16'sh07d0, 80);
        `CHK(gain_monitor > g0, 1'b1)
        halt();
        $display("test gain direction done");
        apb(1'b1, OFF_INIT_GAIN, 32'h0000_ffff);
        apb(1'b0, OFF_GAIN_MON, 32'h0000_0000);
        `CHK(rd, 32'h0000_0bb8)
        spin(16'sh07d0, 40);
        `CHK(gain_monitor, GAIN_MAX)
        halt();
        apb(1'b1, OFF_INIT_GAIN, 32'h0000_03e8);
        apb(1'b1, OFF_CTRL, 32'h0000_0005);
        out_freq <= 16'h2710;
        spin(16'sh07d0, 3);
        `CHK(steady_zone, 1'b0)
        g0 = gain_monitor;
        repeat (40) @(posedge clk);
        `CHK(gain_monitor, g0)
        apb(1'b1, OFF_CTRL, 32'h0000_0007);
        repeat (40) @(posedge clk);
        `CHK(gain_monitor > g0, 1'b1)
        // Clock enable low freezes the integrator
        ce <= 1'b0;
        @(posedge clk);
        g0 = gain_monitor;
        repeat (40) @(posedge clk);
        `CHK(gain_monitor, g0)
        ce <= 1'b1;
        for (int n = 0; n < 3000 && steady_zone !== 1'b1; n++)
            @(posedge clk);
        `CHK(steady_zone, 1'b1)
        if (steady_zone !== 1'b1)
        begin
            report_and_stop();
        end
        halt();
        `CHK(gain_monitor, INIT_GAIN_RST)
        $display("test steady zone done");
        // Reset while stopped returns gain and settings to defaults
        apb(1'b1, OFF_INIT_GAIN, 32'h0000_07d0);
        @(posedge clk);
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        `CHK(gain_monitor, INIT_GAIN_RST)
        apb(1'b0, OFF_GAIN_TAU, 32'h0000_0000);
        `CHK(rd, {16'h0000, GAIN_TAU_RST})
        $display("test reset done");
        report_and_stop();
    end
endmodule // tb_diameterless_comp_gain
